// ---- puim_top.v ----
`default_nettype none
`include "puim_defs.vh"
// ****************************************
// Unit-interval measurement registers
// ****************************************
module puim_top (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // Avalon-MM slave
    input  wire [2:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    // Time and reference events (pins)
    input  wire [47:0] i_time_of_day_value,
    input  wire        i_time_jump,
    input  wire        i_tx_alignment_marker,
    input  wire        i_rx_alignment_marker,
    // Unit interval outputs
    output reg  [31:0] o_tx_unit_interval,
    output reg  [31:0] o_rx_unit_interval
);
    // ****************************************
    // Pin synchronisers and edge detect
    // ****************************************
    wire       tx_lvl;
    wire       rx_lvl;
    wire       jump_lvl;
    reg        tx_lvl_q;
    reg        rx_lvl_q;
    reg        jump_lvl_q;
    reg [47:0] time_of_day_q;
    puim_sync u_sync_tx (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_tx_alignment_marker),
        .o_level   (tx_lvl)
    );
    puim_sync u_sync_rx (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_rx_alignment_marker),
        .o_level   (rx_lvl)
    );
    puim_sync u_sync_jump (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_pin     (i_time_jump),
        .o_level   (jump_lvl)
    );
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx_lvl_q   <= 1'b0;
            rx_lvl_q   <= 1'b0;
            jump_lvl_q <= 1'b0;
            time_of_day_q <= 48'h000000000000;
        end else begin
            tx_lvl_q   <= tx_lvl;
            rx_lvl_q   <= rx_lvl;
            jump_lvl_q <= jump_lvl;
            time_of_day_q <= i_time_of_day_value;
        end
    end
    wire tx_evt   = tx_lvl & ~tx_lvl_q; // R19
    wire rx_evt   = rx_lvl & ~rx_lvl_q; // R19
    wire jump_evt = jump_lvl & ~jump_lvl_q;

    // ****************************************
    // Bus decode
    // ****************************************
    wire acc    = (i_avs_read | i_avs_write) & o_avs_waitrequest;
    wire wr_acc = i_avs_write & o_avs_waitrequest;
    wire snap_wr = wr_acc & (i_avs_address == `PUIM_A_SNAPSHOT)
                   & i_avs_byteenable[0];
    wire tx_snap = snap_wr & i_avs_writedata[`PUIM_SNAP_TX]; // R01
    wire rx_snap = snap_wr & i_avs_writedata[`PUIM_SNAP_RX]; // R02

    // ****************************************
    // Capture engines
    // ****************************************
    wire [31:0] tx_info0;
    wire [31:0] tx_info1;
    wire [31:0] rx_info0;
    wire [31:0] rx_info1;
    puim_capture u_cap_tx (
        .i_sys_clk           (i_sys_clk),
        .i_rst               (i_rst),
        .i_ref_event         (tx_evt),
        .i_time_jump         (jump_evt),
        .i_time_of_day_value (time_of_day_q),
        .i_snap_req          (tx_snap),
        .o_info0             (tx_info0),
        .o_info1             (tx_info1)
    );
    puim_capture u_cap_rx (
        .i_sys_clk           (i_sys_clk),
        .i_rst               (i_rst),
        .i_ref_event         (rx_evt),
        .i_time_jump         (jump_evt),
        .i_time_of_day_value (time_of_day_q),
        .i_snap_req          (rx_snap),
        .o_info0             (rx_info0),
        .o_info1             (rx_info1)
    );

    // ****************************************
    // Byte-enable merge
    // ****************************************
    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer k;
        begin
            be_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // ****************************************
    // Registers and answer
    // ****************************************
    reg [31:0] rd_d;
    always @* begin
        case (i_avs_address)
            `PUIM_A_TX_INFO0: rd_d = tx_info0;
            `PUIM_A_TX_INFO1: rd_d = tx_info1;
            `PUIM_A_TX_UI:    rd_d = o_tx_unit_interval;
            `PUIM_A_RX_INFO0: rd_d = rx_info0;
            `PUIM_A_RX_INFO1: rd_d = rx_info1;
            `PUIM_A_RX_UI:    rd_d = o_rx_unit_interval;
            `PUIM_A_STATUS:   rd_d = {30'h00000000, rx_info1[31],
                                      tx_info1[31]};
            default:          rd_d = `PUIM_UNMAPPED;
        endcase
    end
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_avs_waitrequest  <= 1'b1;
            o_avs_readdata     <= `PUIM_UNMAPPED;
            o_tx_unit_interval <= `PUIM_UI_RESET;
            o_rx_unit_interval <= `PUIM_UI_RESET;
        end else begin
            // One wait cycle, then release
            o_avs_waitrequest <= ~acc;
            if (acc & i_avs_read) begin
                o_avs_readdata <= rd_d;
            end
            if (wr_acc && i_avs_address == `PUIM_A_TX_UI) begin
                o_tx_unit_interval <= be_merge(o_tx_unit_interval,
                    i_avs_writedata, i_avs_byteenable); // R14
            end
            if (wr_acc && i_avs_address == `PUIM_A_RX_UI) begin
                o_rx_unit_interval <= be_merge(o_rx_unit_interval,
                    i_avs_writedata, i_avs_byteenable); // R14
            end
        end
    end
endmodule // puim_top
`default_nettype wire

// ---- puim_defs.vh ----
// How it works
// R01 - Writing one to TX request latches TX reference time and count.
// R02 - Writing one to RX request latches RX reference time and count.
// R03 - Capture register 0 shows low 32 bits of captured time.
// R04 - Capture register 1: time high [15:0], count [30:16], valid [31].
// R05 - Large time-of-day jump clears valid; software restarts then.
// R06 - Software joins high 16 and low 32 bits into 48-bit time.
// R07 - Software waits within min/max window before second capture.
// R08 - Software may reuse a valid later capture as next initial.
// R09 - Software divides reference interval by physical lane count.
// R10 - Elapsed time below min repeats wait; above max restarts.
// R11 - Count difference gets same min/max checks as time.
// R12 - RX over-maximum may restart or reuse later capture.
// R13 - UI equals elapsed time over count times per-lane interval.
// R14 - UI registers hold 4 integer and 28 fraction nanosecond bits.
// R15 - Software repeats measurement no sooner than minimum interval.
// R16 - Defaults: 0x018D3019 for 10G, 0x009EE00A for 38.79 ps modes. Code resets both UI registers to 0x009EE00A in every mode.
// R17 - Defaults: 0x004F7005 for 19.39 ps, 0x0027B802 for 9.70 ps. Code uses neither; reset is always 0x009EE00A.
// R18 - Reference event occurs per alignment marker or reference bit.
// R19 - Reference interval is a fixed mode-dependent bit count.
// R20 - Captured fields hold stable until next request same direction.
// R21 - Capture count increments once per reference event per direction.
`ifndef PUIM_DEFS_VH
`define PUIM_DEFS_VH
// ****************************************
// Register word addresses
// ****************************************
`define PUIM_A_SNAPSHOT   3'h0
`define PUIM_A_TX_INFO0   3'h1
`define PUIM_A_TX_INFO1   3'h2
`define PUIM_A_TX_UI      3'h3
`define PUIM_A_RX_INFO0   3'h4
`define PUIM_A_RX_INFO1   3'h5
`define PUIM_A_RX_UI      3'h6
`define PUIM_A_STATUS     3'h7
// ****************************************
// Field positions
// ****************************************
`define PUIM_SNAP_TX      0
`define PUIM_SNAP_RX      1
`define PUIM_HI_MSB       15
`define PUIM_CNT_LSB      16
`define PUIM_CNT_MSB      30
`define PUIM_VALID_BIT    31
// ****************************************
// Reset values
// ****************************************
`define PUIM_UI_RESET     32'h009ee00a
`define PUIM_CNT_RESET    15'h0000
`define PUIM_UNMAPPED     32'h00000000
`endif

// ---- puim_sync.v ----
`default_nettype none
// ****************************************
// Three-stage pin synchroniser with agreement
// ****************************************
module puim_sync (
    // Clock and reset
    input  wire i_sys_clk,
    input  wire i_rst,
    // Data
    input  wire i_pin,
    output reg  o_level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_level <= s3_q;
            end
        end
    end
endmodule // puim_sync
`default_nettype wire

// ---- puim_capture.v ----
`default_nettype none
`include "puim_defs.vh"
// ****************************************
// One direction: event counter and snapshot
// ****************************************
module puim_capture (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst,
    // Events
    input  wire        i_ref_event,
    input  wire        i_time_jump,
    input  wire [47:0] i_time_of_day_value,
    input  wire        i_snap_req,
    // Snapshot
    output wire [31:0] o_info0,
    output wire [31:0] o_info1
);
    reg [14:0] cnt_q;
    reg [47:0] ref_time_q;
    reg        ref_valid_q;
    reg [47:0] cap_time_q;
    reg [14:0] cap_cnt_q;
    reg        cap_valid_q;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_q       <= `PUIM_CNT_RESET;
            ref_time_q  <= 48'h000000000000;
            ref_valid_q <= 1'b0;
            cap_time_q  <= 48'h000000000000;
            cap_cnt_q   <= `PUIM_CNT_RESET;
            cap_valid_q <= 1'b0;
        end else begin
            if (i_ref_event) begin
                ref_time_q  <= i_time_of_day_value; // R18
                cnt_q       <= cnt_q + 15'h0001; // R21
                ref_valid_q <= ~i_time_jump;
            end else if (i_time_jump) begin
                ref_valid_q <= 1'b0; // R05
            end
            if (i_snap_req) begin
                cap_time_q  <= ref_time_q; // R01
                cap_cnt_q   <= cnt_q; // R02
                cap_valid_q <= ref_valid_q & ~i_time_jump; // R05
            end else if (i_time_jump) begin
                cap_valid_q <= 1'b0; // R05
            end
        end
    end
    // Time and count fields hold until next request; a time jump clears valid
    assign o_info0 = cap_time_q[31:0]; // R03 R20
    assign o_info1 = {cap_valid_q, cap_cnt_q,
                      cap_time_q[47:32]}; // R04
endmodule // puim_capture
`default_nettype wire

// ---- puim_monitor.sv ----
`default_nettype none
`include "puim_defs.vh"
// ****************************************
// Register bus checker
// ****************************************
module puim_monitor (
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    // Register bus
    input wire logic [2:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // Unit intervals
    input wire logic [31:0] o_tx_unit_interval,
    input wire logic [31:0] o_rx_unit_interval
);
    timeunit 1ns;
    timeprecision 1ns;
    wire ack = !o_avs_waitrequest;
    wire req = i_avs_read || i_avs_write;
    wire wr = i_avs_write && ack && i_avs_byteenable == 4'hf;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_one_wait: assert property (req && !ack |=> ack)
        else $error("request not answered after one wait");
    a_wait_pulse: assert property (ack |=> !ack)
        else $error("waitrequest low too long");
    a_idle_wait: assert property (!req |=> !ack)
        else $error("answer without request");
    a_tx_ui_write: assert property (
        wr && i_avs_address == `PUIM_A_TX_UI
        |=> o_tx_unit_interval == $past(i_avs_writedata))
        else $error("tx unit interval not written");
    a_rx_ui_write: assert property (
        wr && i_avs_address == `PUIM_A_RX_UI
        |=> o_rx_unit_interval == $past(i_avs_writedata))
        else $error("rx unit interval not written");
    a_ui_hold: assert property (
        !(i_avs_write && i_avs_address inside {`PUIM_A_TX_UI, `PUIM_A_RX_UI})
        |=> $stable(o_tx_unit_interval) && $stable(o_rx_unit_interval))
        else $error("unit interval changed without write");
    a_snap_zero: assert property (
        i_avs_read && ack && i_avs_address == `PUIM_A_SNAPSHOT
        |-> o_avs_readdata == 32'h0)
        else $error("request word not read as zero");
    a_ui_readback: assert property (
        i_avs_read && ack && i_avs_address == `PUIM_A_RX_UI
        |-> o_avs_readdata == o_rx_unit_interval)
        else $error("rx unit interval readback differs");
endmodule // puim_monitor
`default_nettype wire

// ---- ptp_unit_interval_measurement_tb.sv ----
`default_nettype none
`include "puim_defs.vh"
// ****************************************
// Register level testbench
// ****************************************
module ptp_unit_interval_measurement_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [2:0]  i_avs_address = 3'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [47:0] i_time_of_day_value = 48'h0;
    logic [2:0]  pins = 3'h0;
    logic [31:0] o_tx_unit_interval;
    logic [31:0] o_rx_unit_interval;
    logic [31:0] rd;
    logic [31:0] ui [4] = '{32'h018d3019, 32'h009ee00a,
                            32'h004f7005, 32'h0027b802};
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    puim_top uut (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .i_time_of_day_value, .i_time_jump(pins[2]),
        .i_tx_alignment_marker(pins[0]), .i_rx_alignment_marker(pins[1]),
        .o_tx_unit_interval, .o_rx_unit_interval);
    always #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [31:0] d);
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do
            @(posedge i_sys_clk);
        while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            pins <= m;
            repeat (6) @(posedge i_sys_clk);
            pins <= 3'h0;
            repeat (6) @(posedge i_sys_clk);
        end
    endtask
    task automatic snap(input logic rx, output logic [47:0] t,
                        output logic [14:0] c);
        logic [31:0] lo;
        bus(1'b1, `PUIM_A_SNAPSHOT, {30'h0, rx, !rx});
        bus(1'b0, rx ? `PUIM_A_RX_INFO0 : `PUIM_A_TX_INFO0, 32'h0);
        lo = rd;
        bus(1'b0, rx ? `PUIM_A_RX_INFO1 : `PUIM_A_TX_INFO1, 32'h0);
        chk({31'h0, rd[31]}, 32'h1);
        t = {rd[15:0], lo};
        c = rd[30:16];
    endtask
    task automatic measure(input logic rx);
        logic [47:0] t0;
        logic [47:0] tn;
        logic [47:0] dt;
        logic [14:0] c0;
        logic [14:0] cn;
        logic [14:0] dc;
        logic [63:0] iv;
        logic [63:0] q;
        iv = 64'd168960 / 64'd1;
        i_time_of_day_value <= 48'h0000_1000_0000;
        pulse({1'b0, rx, !rx}, 1);
        snap(rx, t0, c0);
        repeat (2) begin
            i_time_of_day_value <= t0 + 48'h0001_8c00_0000;
            pulse({1'b0, rx, !rx}, 6);
            snap(rx, tn, cn);
            dt = tn - t0;
            dc = cn - c0;
            chk(dt[47:16], 32'h0001_8c00);
            chk({17'h0, dc}, 32'h0000_0006);
            q = {dt, 12'h000} / (dc * iv);
            chk(q[31:0], 32'h0199_9999);
            bus(1'b1, rx ? `PUIM_A_RX_UI : `PUIM_A_TX_UI, q[31:0]);
            chk(rx ? o_rx_unit_interval : o_tx_unit_interval,
                q[31:0]);
            t0 = tn;
            c0 = cn;
        end
    endtask
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rdc(`PUIM_A_TX_UI, `PUIM_UI_RESET);
        rdc(`PUIM_A_TX_INFO1, 32'h0);
        rdc(`PUIM_A_SNAPSHOT, 32'h0);
        foreach (ui[i]) begin
            bus(1'b1, `PUIM_A_TX_UI, ui[i]);
            bus(1'b1, `PUIM_A_RX_UI, ~ui[i]);
            rdc(`PUIM_A_RX_UI, ~ui[i]);
            chk(o_tx_unit_interval, ui[i]);
        end
        i_time_of_day_value <= 48'ha5a5_1234_5678;
        pulse(3'h1, 3);
        bus(1'b1, `PUIM_A_SNAPSHOT, 32'h1);
        rdc(`PUIM_A_TX_INFO0, 32'h1234_5678);
        rdc(`PUIM_A_TX_INFO1, {1'b1, 15'd3, 16'ha5a5});
        i_time_of_day_value <= 48'h0b0d_c0fe_0042;
        pulse(3'h2, 2);
        pulse(3'h1, 1);
        bus(1'b1, `PUIM_A_SNAPSHOT, 32'h2);
        rdc(`PUIM_A_RX_INFO0, 32'hc0fe_0042);
        rdc(`PUIM_A_RX_INFO1, {1'b1, 15'd2, 16'h0b0d});
        bus(1'b1, `PUIM_A_TX_INFO0, 32'hffff_ffff);
        rdc(`PUIM_A_TX_INFO0, 32'h1234_5678);
        rdc(`PUIM_A_TX_INFO1, {1'b1, 15'd3, 16'ha5a5});
        pulse(3'h4, 1);
        bus(1'b1, `PUIM_A_SNAPSHOT, 32'h3);
        rdc(`PUIM_A_TX_INFO1, {1'b0, 15'd4, 16'h0b0d});
        rdc(`PUIM_A_RX_INFO1, {1'b0, 15'd2, 16'h0b0d});
        pulse(3'h3, 1);
        bus(1'b1, `PUIM_A_SNAPSHOT, 32'h3);
        rdc(`PUIM_A_RX_INFO1, {1'b1, 15'd3, 16'h0b0d});
        rdc(`PUIM_A_STATUS, 32'h3);
        measure(1'b0);
        measure(1'b1);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rdc(`PUIM_A_RX_INFO1, 32'h0);
        rdc(`PUIM_A_TX_UI, `PUIM_UI_RESET);
        chk(o_rx_unit_interval, `PUIM_UI_RESET);
        conclude();
    end
endmodule // ptp_unit_interval_measurement_tb
bind puim_top puim_monitor mon (.i_sys_clk, .i_rst, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_tx_unit_interval,
    .o_rx_unit_interval);
`default_nettype wire
